/* verilog/sgs_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sgs_top
  import sgs_pkg::*;
#(
  parameter int TICK_CYC    = sgs_pkg::SGS_TICK_CYC,
  parameter int DISABLE_MS  = sgs_pkg::SGS_DISABLE_MS
) (
  input  wire logic        mclk,                 // System clock
  input  wire logic        rst_n,                // Async reset, active low
  input  wire logic        contact_input_one,    // Contact input 1
  input  wire logic        contact_input_two,    // Contact input 2
  input  wire logic        contact_input_three,  // Contact input 3
  input  wire logic [3:0]  reg_addr,             // Register word address
  input  wire logic [31:0] reg_wdata,            // Write data
  input  wire logic        reg_wr,               // Write strobe
  input  wire logic        reg_rd,               // Read strobe
  output logic [31:0]      reg_rdata,            // Read data, cycle after strobe
  output logic [2:0]       active_group,         // Active group 1..6
  output logic             protection_disable,   // Protection blocked
  output logic             alarm_close,          // Alarm contact closed
  output logic             element_reset,        // Timers and elements reset
  output logic             demand_clear,         // Demand clear pulse
  output logic             irq                   // Level interrupt
);
  import sgs_pkg::*;

  // ==========================================================
  // Registers
  logic [31:0]   ctrl_ff;
  logic [15:0]   group_settle_time_ff;
  logic [2:0]    irq_st_ff;
  logic [2:0]    irq_en_ff;
  logic          tick;
  sgs_state_type state_ff;
  logic [2:0]    sel_prev_ff;
  logic [15:0]   settle_cnt_ff;
  logic [15:0]   dis_cnt_ff;
  logic [2:0]    cmd_prev_ff;
  logic [2:0]    group_select_bit;
  logic [2:0]    cmd_group;
  logic [2:0]    target;
  logic          any_map;
  logic          sel_change;
  logic          settle_expire;
  logic          switch_now;
  logic          cmd_change;
  logic          ev_change;
  logic          ev_reject;
  logic          ev_done;
  logic [2:0]    irq_set;
  logic          wr_ctrl;

  function automatic logic [2:0] sgs_legal(input logic [2:0] g);
    sgs_legal = (g >= 3'h1 && g <= 3'(SGS_GROUPS)) ? g : SGS_GRP_RESET;
  endfunction

  sgs_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  assign wr_ctrl = reg_wr && (reg_addr == SGS_REG_CTRL);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= SGS_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= {24'h00_0000, reg_wdata[7:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      group_settle_time_ff <= SGS_SETTLE_RESET;
    end else if (reg_wr && reg_addr == SGS_REG_SETTLE) begin
      group_settle_time_ff <= reg_wdata[15:0];
    end
  end

  // ==========================================================
  // Selection code
  always_comb begin
    group_select_bit[0] = ctrl_ff[SGS_CTRL_MAP0] & contact_input_one;
    group_select_bit[1] = ctrl_ff[SGS_CTRL_MAP1] & contact_input_two;
    group_select_bit[2] = ctrl_ff[SGS_CTRL_MAP2] & contact_input_three;
  end
  assign any_map   = ctrl_ff[SGS_CTRL_MAP0] | ctrl_ff[SGS_CTRL_MAP1] | ctrl_ff[SGS_CTRL_MAP2];
  assign cmd_group = sgs_legal(ctrl_ff[SGS_CTRL_CMD_LSB +: 3]);

  // Codes 0 and 7 fall back to the commanded group
  always_comb begin
    if (!any_map) begin
      target = cmd_group;
    end else if (group_select_bit == SGS_CODE_CMD_LO || group_select_bit == SGS_CODE_CMD_HI) begin
      target = cmd_group;
    end else begin
      target = group_select_bit;
    end
  end

  assign sel_change    = (group_select_bit != sel_prev_ff);
  assign settle_expire = (state_ff == SGS_SETTLE) && !sel_change && tick &&
                         (settle_cnt_ff >= group_settle_time_ff);
  assign cmd_change    = (cmd_group != cmd_prev_ff);
  // Command changes act at once in SGS_IDLE only; input changes go through the settle wait
  assign switch_now    = (state_ff != SGS_DISABLE) && (target != active_group) &&
                         (settle_expire || (cmd_change && state_ff == SGS_IDLE) ||
                          (state_ff == SGS_IDLE && !sel_change && !any_map));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_ff <= 3'h0;
      cmd_prev_ff <= SGS_GRP_RESET;
    end else begin
      sel_prev_ff <= group_select_bit;
      cmd_prev_ff <= cmd_group;
    end
  end

  // ==========================================================
  // Settle and disable sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= SGS_IDLE;
      settle_cnt_ff <= 16'h0000;
      dis_cnt_ff    <= 16'h0000;
    end else begin
      unique case (state_ff)
        SGS_IDLE: begin
          if (switch_now) begin
            state_ff   <= SGS_DISABLE;
            dis_cnt_ff <= 16'h0000;
          end else if (sel_change) begin
            state_ff      <= SGS_SETTLE;
            settle_cnt_ff <= 16'h0000;
          end
        end
        SGS_SETTLE: begin
          if (sel_change) begin
            settle_cnt_ff <= 16'h0000;
          end else if (settle_expire) begin
            // Code sampled right here decides; reverted inputs give no switch
            state_ff   <= switch_now ? SGS_DISABLE : SGS_IDLE;
            dis_cnt_ff <= 16'h0000;
          end else if (tick && settle_cnt_ff != 16'hFFFF) begin
            settle_cnt_ff <= settle_cnt_ff + 16'h0001;
          end
        end
        SGS_DISABLE: begin
          // Ends under half a second so protection returns promptly
          if (tick) begin
            if (dis_cnt_ff >= 16'(DISABLE_MS - 1)) begin
              state_ff <= SGS_IDLE;
            end else begin
              dis_cnt_ff <= dis_cnt_ff + 16'h0001;
            end
          end
        end
        default: state_ff <= SGS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_group <= SGS_GRP_RESET;
    end else if (switch_now) begin
      active_group <= sgs_legal(target);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      protection_disable <= 1'b0;
      alarm_close        <= 1'b0;
      element_reset      <= 1'b0;
    end else begin
      protection_disable <= switch_now || (state_ff == SGS_DISABLE && !ev_done);
      alarm_close        <= switch_now || (state_ff == SGS_DISABLE && !ev_done);
      element_reset      <= switch_now || (state_ff == SGS_DISABLE && !ev_done);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      demand_clear <= 1'b0;
    end else begin
      demand_clear <= switch_now && ctrl_ff[SGS_CTRL_DEMCLR];
    end
  end

  // ==========================================================
  // Interrupts
  assign ev_change = switch_now;
  assign ev_reject = settle_expire && !switch_now;
  assign ev_done   = (state_ff == SGS_DISABLE) && tick && (dis_cnt_ff >= 16'(DISABLE_MS - 1));
  assign irq_set   = {ev_done, ev_reject, ev_change};

  // Set beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_ff <= 3'h0;
    end else if (reg_wr && reg_addr == SGS_REG_IRQ_CLR) begin
      irq_st_ff <= (irq_st_ff & ~reg_wdata[2:0]) | irq_set;
    end else begin
      irq_st_ff <= irq_st_ff | irq_set;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_ff <= 3'h0;
    end else if (reg_wr && reg_addr == SGS_REG_IRQ_EN) begin
      irq_en_ff <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_st_ff | irq_set) & irq_en_ff);
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SGS_REG_CTRL:    reg_rdata <= ctrl_ff;
        SGS_REG_SETTLE:  reg_rdata <= {16'h0000, group_settle_time_ff};
        SGS_REG_STATUS:  reg_rdata <= {22'h00_0000, state_ff, group_select_bit, active_group,
                                       protection_disable, demand_clear};
        SGS_REG_IRQ_ST:  reg_rdata <= {29'h0000_0000, irq_st_ff};
        SGS_REG_IRQ_EN:  reg_rdata <= {29'h0000_0000, irq_en_ff};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* verilog/sgs_pkg.sv */
package sgs_pkg;
  // ==========================================================
  // Groups and codes
  localparam int           SGS_GROUPS      = 6;
  localparam logic [2:0]   SGS_GRP_RESET   = 3'h1;
  localparam logic [2:0]   SGS_CODE_CMD_LO = 3'h0;
  localparam logic [2:0]   SGS_CODE_CMD_HI = 3'h7;
  // ==========================================================
  // Register map (word addresses on the plain port)
  localparam logic [3:0]   SGS_REG_CTRL    = 4'h0;
  localparam logic [3:0]   SGS_REG_SETTLE  = 4'h1;
  localparam logic [3:0]   SGS_REG_STATUS  = 4'h2;
  localparam logic [3:0]   SGS_REG_IRQ_ST  = 4'h3;
  localparam logic [3:0]   SGS_REG_IRQ_EN  = 4'h4;
  localparam logic [3:0]   SGS_REG_IRQ_CLR = 4'h5;
  // CTRL fields
  localparam int           SGS_CTRL_CMD_LSB = 0;
  localparam int           SGS_CTRL_MAP0    = 4;
  localparam int           SGS_CTRL_MAP1    = 5;
  localparam int           SGS_CTRL_MAP2    = 6;
  localparam int           SGS_CTRL_DEMCLR  = 7;
  localparam logic [31:0]  SGS_CTRL_RESET   = 32'h0000_0001;
  // IRQ bits
  localparam int           SGS_IRQ_CHANGE   = 0;
  localparam int           SGS_IRQ_REJECT   = 1;
  localparam int           SGS_IRQ_DONE     = 2;
  // ==========================================================
  // Timing
  localparam int           SGS_CLK_MHZ      = 250;
  localparam int           SGS_TICK_US      = 1000;
  localparam int           SGS_TICK_CYC     = SGS_TICK_US * SGS_CLK_MHZ;
  localparam int           SGS_DISABLE_MS   = 400;
  localparam logic [15:0]  SGS_SETTLE_RESET = 16'h0001;
  typedef enum logic [1:0] {
    SGS_IDLE    = 2'b00,
    SGS_SETTLE  = 2'b01,
    SGS_DISABLE = 2'b10
  } sgs_state_type;
endpackage

/* verilog/sgs_tick.sv */
`timescale 1ns/1ns
`default_nettype none
module sgs_tick #(
  parameter int TICK_CYC = 250000
) (
  input  wire logic mclk,   // System clock
  input  wire logic rst_n,  // Async reset, active low
  output logic      tick    // One-cycle millisecond pulse
);
  logic [31:0] cnt_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0000_0000;
      tick   <= 1'b0;
    end else if (cnt_ff == 32'(TICK_CYC - 1)) begin
      cnt_ff <= 32'h0000_0000;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tb/sgs_contacts.sv */
`timescale 1ns/1ns
`default_nettype none
module sgs_contacts (
  input  wire logic       mclk,     // Clock
  input  wire logic [2:0] code,     // Requested levels
  output logic            c_one,    // Contact one
  output logic            c_two,    // Contact two
  output logic            c_three   // Contact three
);
  // Synced field contacts move one edge after the request
  always_ff @(posedge mclk) begin
    c_one   <= code[0];
    c_two   <= code[1];
    c_three <= code[2];
  end
endmodule
`default_nettype wire

/* tb/sgs_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module sgs_top_asserts #(
  parameter int TICK_CYC   = 10,
  parameter int DISABLE_MS = 3
) (
  input wire logic        mclk,                // Clock
  input wire logic        rst_n,               // Reset
  input wire logic        reg_rd,              // Read strobe
  input wire logic [31:0] reg_rdata,           // Read data
  input wire logic [2:0]  active_group,        // Group
  input wire logic        protection_disable,  // Block
  input wire logic        alarm_close,         // Alarm
  input wire logic        element_reset,       // Element reset
  input wire logic        demand_clear,        // Demand clear
  input wire logic        irq                  // Interrupt
);
  // One tick of slack: the divider runs free of the change
  localparam int DIS_MAX = (DISABLE_MS + 1) * TICK_CYC + 2;
  logic [31:0] dis_cnt_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dis_cnt_ff <= 32'h0;
    end else begin
      dis_cnt_ff <= protection_disable ? dis_cnt_ff + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  group_range_a: assert property (active_group >= 3'h1 && active_group <= 3'h6)
    else $error("active group out of range");
  change_blocks_a: assert property ($changed(active_group) |-> ##[0:1] protection_disable)
    else $error("group change without disable");
  disable_short_a: assert property (dis_cnt_ff <= DIS_MAX)
    else $error("disable too long");
  disable_min_a: assert property ($rose(protection_disable) |-> protection_disable [*8])
    else $error("disable too short");
  alarm_reset_a: assert property (protection_disable |-> alarm_close && element_reset)
    else $error("alarm or reset missing");
  reset_inside_a: assert property (element_reset || alarm_close |-> protection_disable)
    else $error("reset outside disable");
  demand_pulse_a: assert property (demand_clear |=> !demand_clear)
    else $error("demand clear not a pulse");
  demand_change_a: assert property (demand_clear |-> ##[0:1] protection_disable)
    else $error("demand clear without change");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  change_c: cover property ($changed(active_group));
  demand_c: cover property (demand_clear);
  irq_c: cover property ($rose(irq));
endmodule
bind sgs_top sgs_top_asserts #(.TICK_CYC(TICK_CYC), .DISABLE_MS(DISABLE_MS)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .active_group(active_group), .protection_disable(protection_disable),
  .alarm_close(alarm_close), .element_reset(element_reset),
  .demand_clear(demand_clear), .irq(irq));
`default_nettype wire

/* tb/setting_group_selector_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module setting_group_selector_test;
  import sgs_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd, c1, c2, c3;
  logic        protection_disable, alarm_close, element_reset, demand_clear, irq;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [2:0]  code, active_group;
  int          err_count, n_compared, dc_cnt, exp_dc, cmd, map, dem, cur;
  sgs_contacts part_u (.mclk(mclk), .code(code), .c_one(c1), .c_two(c2), .c_three(c3));
  sgs_top #(.TICK_CYC(10), .DISABLE_MS(3)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .contact_input_one(c1), .contact_input_two(c2), .contact_input_three(c3),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .active_group(active_group), .protection_disable(protection_disable),
    .alarm_close(alarm_close), .element_reset(element_reset), .demand_clear(demand_clear),
    .irq(irq));
  // ==========================================================
  // Reference model
  function automatic int exp_grp(int cd);
    int c;
    c = cd & map;
    if (c >= 1 && c <= 6) return c;
    return (cmd >= 1 && cmd <= 6) ? cmd : 1;
  endfunction
  task automatic upd(int g);
    if (g != cur && dem != 0) exp_dc++;
    cur = g;
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input int d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= 32'(d);
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Quiet long enough that any settle has expired and disable ended
  task automatic step();
    int q;
    q = 0;
    for (int n = 0; n < 2000 && q < 60; n++) begin
      @(posedge mclk);
      q = (protection_disable === 1'b0) ? q + 1 : 0;
    end
    `CHK(q, 60)
    `CHK(active_group, 3'(cur))
    `CHK(dc_cnt, exp_dc)
  endtask
  task automatic ctl(int c, int m, int d);
    code <= 3'h0;
    upd(exp_grp(0));
    step();
    cmd = c;
    map = m;
    dem = d;
    wr(SGS_REG_CTRL, (d << SGS_CTRL_DEMCLR) | (m << SGS_CTRL_MAP0) | c);
    upd(exp_grp(0));
    step();
  endtask
  always @(posedge mclk) if (demand_clear === 1'b1) dc_cnt++;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #160000;
    err_count++;
    end_of_test();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, code} = '0;
    {err_count, n_compared, dc_cnt, exp_dc, map, dem} = '0;
    cmd = 1;
    cur = 1;
    void'($urandom(32'hA1DEC323));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    #1 `CHK(active_group, SGS_GRP_RESET)
    rd(SGS_REG_CTRL, rv);
    `CHK(rv, SGS_CTRL_RESET)
    rd(SGS_REG_SETTLE, rv);
    `CHK(rv, {16'h0, SGS_SETTLE_RESET})
    rd(4'hF, rv);
    `CHK(rv, 32'h0)
    wr(SGS_REG_SETTLE, 2);
    for (int g = 2; g < 10; g++) begin
      ctl(g % 8, 0, 0);
      code <= 3'($urandom);
      step();
    end
    ctl(5, 7, 1);
    for (int cd = 0; cd < 8; cd++) begin
      code <= 3'(cd);
      upd(exp_grp(cd));
      step();
    end
    code <= 3'h3;
    upd(3);
    step();
    code <= 3'h5;
    @(posedge mclk);
    code <= 3'h3;
    step();
    code <= 3'h6;
    repeat (15) @(posedge mclk);
    code <= 3'h2;
    upd(2);
    step();
    ctl(4, 1, 0);
    for (int cd = 6; cd < 8; cd++) begin
      code <= 3'(cd);
      upd(exp_grp(cd));
      step();
    end
    wr(SGS_REG_IRQ_EN, 0);
    ctl(cur % 6 + 1, 0, 0);
    `CHK(irq, 1'b0)
    wr(SGS_REG_IRQ_EN, 1 << SGS_IRQ_CHANGE);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b1)
    rd(SGS_REG_IRQ_ST, rv);
    `CHK(rv[SGS_IRQ_CHANGE], 1'b1)
    wr(SGS_REG_IRQ_CLR, 7);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0)
    rd(SGS_REG_IRQ_CLR, rv);
    `CHK(rv, 32'h0)
    rd(SGS_REG_STATUS, rv);
    `CHK(rv[4:2], 3'(cur))
    `CHK(rv[1], 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire
